// ### dv/mesh_link_diag_counters_tb.sv
// self-checking bench for mldc_top: counters, settings, irq, rebroadcast.
// assumes mldc_host_bfm as bus master and the bound mldc_monitor.
`timescale 1ns/1ps
module mesh_link_diag_counters_tb;
  import mldc_pkg::*;
  localparam int unsigned SLOT_C = 8; // short slot keeps the run brief
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1; // clock enable, low freezes the block
  logic [4:0] evt = 5'h00; // tx byte, good, ack timeout, tx fail, acked
  logic rx_pkt = 1'b0;
  logic [7:0] rx_lvl = 8'h00;
  logic rb_req = 1'b0;
  logic cyc, stb, we, ack, end_dev, relay, go, net_ack, mac_ack, irq;
  logic [7:0] adr;
  logic [3:0] sel, net_max, mac_max;
  logic [31:0] wdat, rdat;
  logic [5:0] eff_rad, hops;
  int fails = 0;
  int num_checks = 0;
  always #12.5 clk = ~clk;
  mldc_host_bfm i_host (.core_clk_i(clk), .wb_ack_i(ack), .wb_dat_i(rdat), .wb_cyc_o(cyc),
    .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(wdat));
  mldc_top #(.SLOT_CYCLES(SLOT_C)) i_dut (.core_clk_i(clk), .srst_i(srst), .ce_i(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tx_byte_i(evt[0]),
    .good_frame_i(evt[1]), .ack_timeout_i(evt[2]), .tx_failure_i(evt[3]),
    .acked_unicast_i(evt[4]), .rx_packet_i(rx_pkt), .rx_level_i(rx_lvl),
    .rebroadcast_req_i(rb_req), .end_device_o(end_dev), .relay_allow_o(relay),
    .eff_radius_o(eff_rad), .max_hop_estimate_o(hops), .rebroadcast_go_o(go),
    .net_ack_req_o(net_ack), .net_attempt_max_o(net_max), .mac_ack_req_o(mac_ack),
    .mac_attempt_max_o(mac_max), .irq_o(irq));
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // event strobes high for n cycles
  task automatic pulse(input logic [4:0] m, input int n);
    evt <= m;
    repeat (n) @(posedge clk);
    evt <= 5'h00;
    @(posedge clk);
  endtask
  // reset values of counters, settings and derived outputs
  task automatic t_defaults();
    logic [7:0] ofs [11] = '{OFS_TX_BYTE, OFS_GOOD_FRAME, OFS_ACK_TIMEOUT, OFS_TX_FAILURE,
      OFS_ACKED_UNI, OFS_NODE_ROLE, OFS_BC_RADIUS, OFS_MAX_HOP, OFS_SLOT_MAX,
      OFS_MESH_RETRY, OFS_LINK_ATTEMPT};
    logic [7:0] exp [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07,
      8'h03, 8'h01, 8'h0A};
    for (int i = 0; i < 11; i++) rd_chk(ofs[i], {24'h0, exp[i]});
    chk({eff_rad, hops, end_dev, relay}, {6'h20, 6'h07, 2'b01});
    chk({net_ack, net_max, mac_ack, mac_max}, {1'b1, 4'h2, 1'b1, 4'hA});
    rd_chk(OFS_UNI_HOP_MS, 32'(11 * UNI_ATTEMPT_MS_DFLT));
    rd_chk(OFS_BC_HOP_MS, 32'(3 * SLOT_MS + BC_TX_MS_DFLT));
    rd_chk(8'h80, 32'h0); // unmapped reads zero
  endtask
  // wrap raises a status bit; irq masked, enabled, cleared
  task automatic t_wrap();
    w(OFS_TX_BYTE, 32'h0000FFFE);
    pulse(5'h01, 2);
    rd_chk(OFS_TX_BYTE, 32'h0);
    rd_chk(OFS_IRQ_STATUS, 32'h1);
    chk(irq, 1'b0);
    w(OFS_IRQ_ENABLE, 32'h1);
    chk(irq, 1'b1);
    w(OFS_IRQ_CLEAR, 32'h1);
    rd_chk(OFS_IRQ_STATUS, 32'h0);
    chk(irq, 1'b0);
  endtask
  // preset against same-cycle event, then saturation
  task automatic t_sat();
    fork
      w(OFS_TX_BYTE, 32'h1234);
      pulse(5'h01, 1);
    join
    rd_chk(OFS_TX_BYTE, 32'h1234);
    w(OFS_ACK_TIMEOUT, 32'hFFFE);
    w(OFS_ACKED_UNI, 32'hFFFE);
    pulse(5'h14, 3);
    rd_chk(OFS_ACK_TIMEOUT, 32'hFFFF);
    rd_chk(OFS_ACKED_UNI, 32'hFFFF);
    w(OFS_GOOD_FRAME, 32'h1234);
    rd_chk(OFS_GOOD_FRAME, 32'h0);
    pulse(5'h0A, 65537);
    rd_chk(OFS_GOOD_FRAME, 32'hFFFF);
    rd_chk(OFS_TX_FAILURE, 32'hFFFF);
    rx_lvl <= 8'h60;
    rx_pkt <= 1'b1;
    @(posedge clk);
    rx_pkt <= 1'b0;
    rx_lvl <= 8'h21;
    @(posedge clk);
    rd_chk(OFS_SIG_LEVEL, 32'h60);
    // events while the clock enable is low must not count
    ce <= 1'b0;
    pulse(5'h01, 3);
    ce <= 1'b1;
    rd_chk(OFS_TX_BYTE, 32'h1234);
    rd_chk(OFS_IRQ_STATUS, 32'h3E); // every event flag but the wrap
  endtask
  // ranges, clamp and derived timeouts
  task automatic t_params();
    w(OFS_BC_RADIUS, 32'h10);
    chk(eff_rad, 6'h07);
    w(OFS_MAX_HOP, 32'h20);
    chk({eff_rad, hops}, {6'h10, 6'h20});
    w(OFS_BC_RADIUS, 32'h21);
    rd_chk(OFS_BC_RADIUS, 32'h10);
    w(OFS_MAX_HOP, 32'h0);
    rd_chk(OFS_MAX_HOP, 32'h20);
    w(OFS_MESH_RETRY, 32'h0);
    chk({net_ack, net_max}, {1'b0, 4'h1});
    w(OFS_MESH_RETRY, 32'h7);
    chk({net_ack, net_max}, {1'b1, 4'h8});
    w(OFS_LINK_ATTEMPT, 32'h0);
    chk({mac_ack, mac_max}, 5'h00);
    rd_chk(OFS_UNI_HOP_MS, 32'(UNI_ATTEMPT_MS_DFLT));
    w(OFS_SLOT_MAX, 32'h0);
    rd_chk(OFS_SLOT_MAX, 32'h3);
    w(OFS_SLOT_MAX, 32'hA);
    rd_chk(OFS_BC_HOP_MS, 32'(10 * SLOT_MS + BC_TX_MS_DFLT));
  endtask
  // end device stays silent; router answers after one slot
  task automatic t_rebroadcast();
    int n;
    w(OFS_NODE_ROLE, 32'h1);
    rd_chk(OFS_NODE_ROLE, 32'h0);
    w(OFS_NODE_ROLE, 32'h2);
    chk({end_dev, relay}, 2'b10);
    rb_req <= 1'b1;
    @(posedge clk);
    rb_req <= 1'b0;
    n = 0;
    repeat (200) begin
      @(posedge clk);
      if (go === 1'b1) n++;
    end
    chk(n, 0);
    w(OFS_NODE_ROLE, 32'h0);
    w(OFS_SLOT_MAX, 32'h1);
    rb_req <= 1'b1;
    @(posedge clk);
    rb_req <= 1'b0;
    for (n = 1; n < 200 && go !== 1'b1; n++) @(posedge clk);
    chk(n >= SLOT_C && n <= SLOT_C + 3, 1'b1);
  endtask
  // verdict and stop
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_defaults();
    t_wrap();
    t_sat();
    t_params();
    t_rebroadcast();
    end_of_test();
  end
  // watchdog: about 66k cycles expected
  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule // mesh_link_diag_counters_tb

// ### dv/mldc_host_bfm.sv
// host controller model: classic wishbone master issuing commands.
// assumes xfer is called just after a rising edge of core_clk_i.
`timescale 1ns/1ps
module mldc_host_bfm (
  input wire logic core_clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  // idle bus at time zero
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0;
  end
  // one cycle, held until ack is seen at an edge; preset writes too
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= w;
    wb_adr_o <= a;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    do @(posedge core_clk_i); while (wb_ack_i !== 1'b1);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    // released lines must not keep showing the old value
    wb_adr_o <= ~a;
    wb_dat_o <= ~d;
    @(posedge core_clk_i);
  endtask
endmodule // mldc_host_bfm

// ### dv/mldc_monitor.sv
// checker for mldc_top: bus answer and derived control outputs.
// assumes it is bound to mldc_top and sees only its ports.
`timescale 1ns/1ps
module mldc_monitor #(
  parameter int unsigned SLOT_CYCLES = 8 // rebroadcast slot, cycles
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic end_device_o,
  input wire logic relay_allow_o,
  input wire logic [5:0] eff_radius_o,
  input wire logic [5:0] max_hop_estimate_o,
  input wire logic rebroadcast_go_o,
  input wire logic net_ack_req_o,
  input wire logic [3:0] net_attempt_max_o,
  input wire logic mac_ack_req_o,
  input wire logic [3:0] mac_attempt_max_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  logic [23:0] since_go; // clocks since the last go pulse, saturating
  // a go needs at least one whole slot after the previous go or reset
  always_ff @(posedge core_clk_i) begin
    if (srst_i || rebroadcast_go_o) begin
      since_go <= 24'h000000;
    end else if (ce_i && since_go != 24'hFFFFFF) begin
      since_go <= since_go + 24'h000001;
    end
  end
  // request taken at this edge
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  endsequence
  // ack stands exactly one cycle
  sequence s_ack_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_ANSWER: assert property (s_req |=> s_ack_pulse)
    else $error("bus request not answered by one ack");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // derived outputs are still reset values on the first edge after release
  AST_ROLE_RELAY: assert property (!$past(srst_i) |->
    end_device_o != relay_allow_o)
    else $error("relay permission does not follow role");
  AST_GO_PULSE: assert property (rebroadcast_go_o |=> !rebroadcast_go_o)
    else $error("rebroadcast go longer than one cycle");
  // the radius output lags the hop estimate by one cycle
  AST_RADIUS: assert property (eff_radius_o == 6'h20 ||
    (eff_radius_o != 6'h00 && eff_radius_o <= $past(max_hop_estimate_o)))
    else $error("effective radius above hop estimate");
  AST_HOP_RANGE: assert property (max_hop_estimate_o inside {[6'h01:6'h20]})
    else $error("hop estimate out of range");
  AST_NET_ACK: assert property (!$past(srst_i) |->
    net_ack_req_o == (net_attempt_max_o != 4'h1) && net_attempt_max_o inside {[4'h1:4'h8]})
    else $error("network ack request disagrees with attempts");
  AST_MAC_ACK: assert property (mac_ack_req_o == (mac_attempt_max_o != 4'h0))
    else $error("mac ack request disagrees with attempts");
  AST_GO_ROUTER: assert property (rebroadcast_go_o |->
    relay_allow_o && !end_device_o)
    else $error("rebroadcast go on an end device");
  AST_GO_DELAY: assert property (rebroadcast_go_o |-> since_go >= SLOT_CYCLES)
    else $error("rebroadcast go before one slot");
endmodule // mldc_monitor

bind mldc_top mldc_monitor #(.SLOT_CYCLES(SLOT_CYCLES)) i_mon (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .end_device_o(end_device_o),
  .relay_allow_o(relay_allow_o), .eff_radius_o(eff_radius_o),
  .max_hop_estimate_o(max_hop_estimate_o), .rebroadcast_go_o(rebroadcast_go_o),
  .net_ack_req_o(net_ack_req_o), .net_attempt_max_o(net_attempt_max_o),
  .mac_ack_req_o(mac_ack_req_o), .mac_attempt_max_o(mac_attempt_max_o));

// ### src/mldc_pkg.sv
// package for the mesh link diagnostic counter block: register map,
// reset values, ranges and timing constants.
// assumes a 40 MHz core clock and a 32-bit classic wishbone register bus.
package mldc_pkg;
  // clock and timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned SLOT_MS = 13; // one rebroadcast delay slot, ms
  localparam int unsigned SLOT_CYCLES_DFLT = (CLK_HZ / 1000) * SLOT_MS;
  localparam int unsigned UNI_ATTEMPT_MS_DFLT = 10; // per-attempt unicast hop budget
  localparam int unsigned BC_TX_MS_DFLT = 18; // broadcast airtime budget

  // register byte offsets
  localparam logic [7:0] OFS_TX_BYTE = 8'h00;
  localparam logic [7:0] OFS_SIG_LEVEL = 8'h04;
  localparam logic [7:0] OFS_GOOD_FRAME = 8'h08;
  localparam logic [7:0] OFS_ACK_TIMEOUT = 8'h0C;
  localparam logic [7:0] OFS_TX_FAILURE = 8'h10;
  localparam logic [7:0] OFS_ACKED_UNI = 8'h14;
  localparam logic [7:0] OFS_UNI_HOP_MS = 8'h18;
  localparam logic [7:0] OFS_BC_HOP_MS = 8'h1C;
  localparam logic [7:0] OFS_NODE_ROLE = 8'h20;
  localparam logic [7:0] OFS_BC_RADIUS = 8'h24;
  localparam logic [7:0] OFS_MAX_HOP = 8'h28;
  localparam logic [7:0] OFS_SLOT_MAX = 8'h2C;
  localparam logic [7:0] OFS_MESH_RETRY = 8'h30;
  localparam logic [7:0] OFS_LINK_ATTEMPT = 8'h34;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h3C;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h40;

  // counter limits and reset values
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_RST = 16'h0000;

  // node role encodings
  localparam logic [1:0] ROLE_ROUTER = 2'h0;
  localparam logic [1:0] ROLE_END_DEVICE = 2'h2;

  // parameter ranges and defaults
  localparam logic [5:0] RADIUS_MAX = 6'h20;
  localparam logic [5:0] RADIUS_RST = 6'h00;
  localparam logic [5:0] HOP_MIN = 6'h01;
  localparam logic [5:0] HOP_MAX = 6'h20;
  localparam logic [5:0] HOP_RST = 6'h07;
  localparam logic [3:0] SLOT_MIN = 4'h1;
  localparam logic [3:0] SLOT_MAX = 4'hA;
  localparam logic [3:0] SLOT_RST = 4'h3;
  localparam logic [2:0] MESH_RETRY_RST = 3'h1;
  localparam logic [3:0] LINK_ATTEMPT_RST = 4'hA;

  // interrupt status bit positions
  localparam int unsigned IRQ_W = 6;
  localparam int unsigned IRQ_TX_BYTE_WRAP = 0;
  localparam int unsigned IRQ_GOOD_SAT = 1;
  localparam int unsigned IRQ_ACK_TO_SAT = 2;
  localparam int unsigned IRQ_TX_FAIL_SAT = 3;
  localparam int unsigned IRQ_ACKED_SAT = 4;
  localparam int unsigned IRQ_RSSI_NEW = 5;

  // lfsr seed for the rebroadcast slot draw
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // rebroadcast delay sequencer states
  typedef enum logic [0:0] {RB_IDLE, RB_WAIT} mldc_rb_e;
endpackage

// ### src/mldc_top.sv
// mesh link diagnostic counters and mesh parameter bank, one module.
// assumes synchronous event strobes one clock wide, a classic wishbone
// master that holds each request until ack, and core_clk_i at 40 MHz.
`timescale 1ns/1ps
module mldc_top
  import mldc_pkg::*;
#(
  parameter int unsigned SLOT_CYCLES = SLOT_CYCLES_DFLT,
  parameter int unsigned UNI_ATTEMPT_MS = UNI_ATTEMPT_MS_DFLT,
  parameter int unsigned BC_TX_MS = BC_TX_MS_DFLT
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // mac and radio events
  input wire logic tx_byte_i,
  input wire logic good_frame_i,
  input wire logic ack_timeout_i,
  input wire logic tx_failure_i,
  input wire logic acked_unicast_i,
  input wire logic rx_packet_i,
  input wire logic [7:0] rx_level_i,
  input wire logic rebroadcast_req_i,
  // derived controls
  output logic end_device_o,
  output logic relay_allow_o,
  output logic [5:0] eff_radius_o,
  output logic [5:0] max_hop_estimate_o,
  output logic rebroadcast_go_o,
  output logic net_ack_req_o,
  output logic [3:0] net_attempt_max_o,
  output logic mac_ack_req_o,
  output logic [3:0] mac_attempt_max_o,
  output logic irq_o
);

  // refuse a slot length the 24-bit timer cannot hold
  if (SLOT_CYCLES < 1 || SLOT_CYCLES > 24'hFFFFFF) begin : g_chk_slot
    $error("SLOT_CYCLES out of range");
  end
  // both timeouts must fit their 16-bit read-only registers at the
  // widest settings, ten slots and fifteen link attempts
  if (UNI_ATTEMPT_MS > 4095 || BC_TX_MS > 16'hFF7D) begin : g_chk_ms
    $error("timeout budget out of range");
  end

  localparam logic [23:0] SLOT_LAST = 24'(SLOT_CYCLES - 1);

  // whole module state
  // counters, settings, bus answer, sequencer, then derived flags
  typedef struct packed {
    logic [15:0] tx_byte_count;
    logic [15:0] good_frame_count;
    logic [15:0] ack_timeout_count;
    logic [15:0] tx_failure_count;
    logic [15:0] acked_unicast_count;
    logic [7:0] last_hop_signal_level;
    logic [15:0] uni_hop_ms;
    logic [15:0] bc_hop_ms;
    logic [1:0] node_role;
    logic [5:0] broadcast_radius;
    logic [5:0] max_hop_estimate;
    logic [3:0] rebroadcast_slot_max;
    logic [2:0] mesh_retry_limit;
    logic [3:0] link_attempt_limit;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    logic irq;
    logic wb_ack;
    logic [31:0] wb_dat;
    mldc_rb_e rb_state;
    logic [3:0] rb_slots_left;
    logic [23:0] rb_cycles;
    logic [15:0] lfsr;
    logic rb_go;
    logic end_device;
    logic relay_allow; // inverse of end_device, kept on its own flop
    logic [5:0] eff_radius;
    logic net_ack_req;
    logic [3:0] net_attempt_max;
    logic mac_ack_req;
    logic [3:0] mac_attempt_max;
  } mldc_state_s;

  mldc_state_s st; // registered state
  mldc_state_s next_st; // next state

  // saturating increment, holds at the top
  function automatic logic [15:0] mldc_sat_inc(input logic [15:0] v);
    mldc_sat_inc = (v == CNT_MAX) ? v : v + 16'h0001;
  endfunction

  // pick a random slot count in 1..max
  function automatic logic [3:0] mldc_draw(input logic [15:0] r, input logic [3:0] m);
    logic [3:0] d;
    d = 4'(r[7:0] % {4'h0, m});
    mldc_draw = d + 4'h1;
  endfunction

  logic req; // bus request not yet answered
  logic wr; // write accepted this cycle
  logic [15:0] wmask; // byte-lane mask for 16-bit fields
  logic [15:0] wdat16; // masked write data helper
  logic [31:0] rdat; // read mux
  logic [5:0] radius_eff; // effective broadcast radius
  logic [IRQ_W-1:0] ev; // event pulses into status

  // next-state logic; every field is computed from st and the inputs,
  // and only the irq flag looks at next values already worked out here
  always_comb begin
    req = wb_cyc_i & wb_stb_i & ~st.wb_ack;
    wr = req & wb_we_i;
    wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wdat16 = wb_dat_i[15:0] & wmask;
    next_st = st;
    ev = '0;

    // bus answer: one cycle after the request is seen
    // a write lands at the edge that takes the request, one cycle before
    // the master samples ack; read data is captured at that same edge
    next_st.wb_ack = req;

    // read data mux, unmapped reads give zero
    unique case (wb_adr_i)
      OFS_TX_BYTE: rdat = {16'h0000, st.tx_byte_count};
      OFS_SIG_LEVEL: rdat = {24'h000000, st.last_hop_signal_level};
      OFS_GOOD_FRAME: rdat = {16'h0000, st.good_frame_count};
      OFS_ACK_TIMEOUT: rdat = {16'h0000, st.ack_timeout_count};
      OFS_TX_FAILURE: rdat = {16'h0000, st.tx_failure_count};
      OFS_ACKED_UNI: rdat = {16'h0000, st.acked_unicast_count};
      OFS_UNI_HOP_MS: rdat = {16'h0000, st.uni_hop_ms};
      OFS_BC_HOP_MS: rdat = {16'h0000, st.bc_hop_ms};
      OFS_NODE_ROLE: rdat = {30'h00000000, st.node_role};
      OFS_BC_RADIUS: rdat = {26'h0000000, st.broadcast_radius};
      OFS_MAX_HOP: rdat = {26'h0000000, st.max_hop_estimate};
      OFS_SLOT_MAX: rdat = {28'h0000000, st.rebroadcast_slot_max};
      OFS_MESH_RETRY: rdat = {29'h00000000, st.mesh_retry_limit};
      OFS_LINK_ATTEMPT: rdat = {28'h0000000, st.link_attempt_limit};
      OFS_IRQ_STATUS: rdat = {26'h0000000, st.irq_status};
      OFS_IRQ_ENABLE: rdat = {26'h0000000, st.irq_enable};
      default: rdat = 32'h00000000; // clear register reads zero too
    endcase
    if (req) begin
      next_st.wb_dat = wb_we_i ? 32'h00000000 : rdat;
    end

    // a host preset beats a same-cycle event, so software reads back
    // exactly what it wrote; the dropped event is the price
    // tx byte counter, wraps; preset wins over the event
    // the wrap is flagged so software can extend the count itself
    if (wr && wb_adr_i == OFS_TX_BYTE) begin
      next_st.tx_byte_count = (st.tx_byte_count & ~wmask) | wdat16;
    end else if (tx_byte_i) begin
      next_st.tx_byte_count = st.tx_byte_count + 16'h0001;
      ev[IRQ_TX_BYTE_WRAP] = (st.tx_byte_count == CNT_MAX);
    end

    // good frames, read only and saturating
    // saturation flags fire on the step into the top value, once only
    if (good_frame_i) begin
      next_st.good_frame_count = mldc_sat_inc(st.good_frame_count);
      ev[IRQ_GOOD_SAT] = (st.good_frame_count == CNT_MAX - 16'h0001);
    end

    // ack timeouts, presettable and saturating
    if (wr && wb_adr_i == OFS_ACK_TIMEOUT) begin
      next_st.ack_timeout_count = (st.ack_timeout_count & ~wmask) | wdat16;
    end else if (ack_timeout_i) begin
      next_st.ack_timeout_count = mldc_sat_inc(st.ack_timeout_count);
      ev[IRQ_ACK_TO_SAT] = (st.ack_timeout_count == CNT_MAX - 16'h0001);
    end

    // frames that used every retry, saturating
    if (tx_failure_i) begin
      next_st.tx_failure_count = mldc_sat_inc(st.tx_failure_count);
      ev[IRQ_TX_FAIL_SAT] = (st.tx_failure_count == CNT_MAX - 16'h0001);
    end

    // ack-requested unicasts, presettable and saturating
    if (wr && wb_adr_i == OFS_ACKED_UNI) begin
      next_st.acked_unicast_count = (st.acked_unicast_count & ~wmask) | wdat16;
    end else if (acked_unicast_i) begin
      next_st.acked_unicast_count = mldc_sat_inc(st.acked_unicast_count);
      ev[IRQ_ACKED_SAT] = (st.acked_unicast_count == CNT_MAX - 16'h0001);
    end

    // latch the magnitude of the last received packet level
    // kept as given: a magnitude, to be read as negative dBm
    if (rx_packet_i) begin
      next_st.last_hop_signal_level = rx_level_i;
      ev[IRQ_RSSI_NEW] = 1'b1;
    end

    // mesh parameter writes; out-of-range values are ignored
    // software reads a setting back to learn whether a write was taken
    if (wr && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        OFS_NODE_ROLE: begin
          // only router and end device codes are legal
          if (wb_dat_i[31:0] == {30'h00000000, ROLE_ROUTER} ||
              wb_dat_i[31:0] == {30'h00000000, ROLE_END_DEVICE}) begin
            next_st.node_role = wb_dat_i[1:0];
          end
        end
        OFS_BC_RADIUS: begin
          if (wb_dat_i[31:0] <= {26'h0000000, RADIUS_MAX}) begin
            next_st.broadcast_radius = wb_dat_i[5:0];
          end
        end
        OFS_MAX_HOP: begin
          if (wb_dat_i[31:0] >= {26'h0000000, HOP_MIN} &&
              wb_dat_i[31:0] <= {26'h0000000, HOP_MAX}) begin
            next_st.max_hop_estimate = wb_dat_i[5:0];
          end
        end
        OFS_SLOT_MAX: begin
          if (wb_dat_i[31:0] >= {28'h0000000, SLOT_MIN} &&
              wb_dat_i[31:0] <= {28'h0000000, SLOT_MAX}) begin
            next_st.rebroadcast_slot_max = wb_dat_i[3:0];
          end
        end
        OFS_MESH_RETRY: begin
          if (wb_dat_i[31:3] == 29'h00000000) begin
            next_st.mesh_retry_limit = wb_dat_i[2:0];
          end
        end
        OFS_LINK_ATTEMPT: begin
          if (wb_dat_i[31:4] == 28'h0000000) begin
            next_st.link_attempt_limit = wb_dat_i[3:0];
          end
        end
        OFS_IRQ_ENABLE: begin
          next_st.irq_enable = wb_dat_i[IRQ_W-1:0];
        end
        default: begin
          // other offsets have no parameter behind them
        end
      endcase
    end

    // sticky status: a new event wins over a same-cycle clear
    // clear and enable share the status bit layout
    if (wr && wb_sel_i[0] && wb_adr_i == OFS_IRQ_CLEAR) begin
      next_st.irq_status = (st.irq_status & ~wb_dat_i[IRQ_W-1:0]) | ev;
    end else begin
      next_st.irq_status = st.irq_status | ev;
    end
    next_st.irq = |(next_st.irq_status & next_st.irq_enable);

    // one-hop timeouts track the current parameters
    // recomputed every cycle: a read two cycles after a parameter
    // write already returns the new figure
    next_st.uni_hop_ms = 16'(({12'h000, st.link_attempt_limit} + 16'h0001) *
      16'(UNI_ATTEMPT_MS));
    next_st.bc_hop_ms = 16'({12'h000, st.rebroadcast_slot_max} * 16'(SLOT_MS) +
      16'(BC_TX_MS));

    // effective radius: zero means the widest, clamp to hop estimate
    // registered one cycle behind the settings so the port is a flop
    if (st.broadcast_radius == RADIUS_RST) begin
      radius_eff = RADIUS_MAX;
    end else if (st.broadcast_radius > st.max_hop_estimate) begin
      radius_eff = st.max_hop_estimate;
    end else begin
      radius_eff = st.broadcast_radius;
    end
    next_st.eff_radius = radius_eff;

    // derived controls, registered so the outputs come from flops
    next_st.end_device = (st.node_role == ROLE_END_DEVICE);
    next_st.relay_allow = (st.node_role != ROLE_END_DEVICE);
    next_st.net_ack_req = (st.mesh_retry_limit != 3'h0);
    next_st.net_attempt_max = {1'b0, st.mesh_retry_limit} + 4'h1;
    next_st.mac_ack_req = (st.link_attempt_limit != 4'h0);
    next_st.mac_attempt_max = st.link_attempt_limit;

    // free-running lfsr for the slot draw
    // not a secure source: it only spreads rebroadcasts of nearby nodes
    next_st.lfsr = {st.lfsr[14:0], st.lfsr[15] ^ st.lfsr[13] ^ st.lfsr[12] ^ st.lfsr[10]};

    // rebroadcast delay sequencer
    // each slot lasts SLOT_CYCLES clocks; go is a one-cycle pulse
    next_st.rb_go = 1'b0;
    unique case (st.rb_state)
      RB_IDLE: begin
        // end devices drop rebroadcast requests outright
        if (rebroadcast_req_i && st.node_role != ROLE_END_DEVICE) begin
          next_st.rb_state = RB_WAIT;
          next_st.rb_slots_left = mldc_draw(st.lfsr, st.rebroadcast_slot_max);
          next_st.rb_cycles = 24'h000000;
        end
      end
      RB_WAIT: begin
        // a role change mid-wait cancels the pending rebroadcast
        if (st.node_role == ROLE_END_DEVICE) begin
          next_st.rb_state = RB_IDLE;
        end else if (st.rb_cycles == SLOT_LAST) begin
          next_st.rb_cycles = 24'h000000;
          if (st.rb_slots_left == 4'h1) begin
            next_st.rb_state = RB_IDLE;
            next_st.rb_go = 1'b1;
          end else begin
            next_st.rb_slots_left = st.rb_slots_left - 4'h1;
          end
        end else begin
          next_st.rb_cycles = st.rb_cycles + 24'h000001;
        end
      end
    endcase
  end

  // single state register, frozen while ce_i is low
  // reset does not wait for ce_i, so the bank always starts clean
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st <= '0;
      st.tx_byte_count <= CNT_RST;
      st.ack_timeout_count <= CNT_RST;
      st.acked_unicast_count <= CNT_RST;
      st.node_role <= ROLE_ROUTER;
      st.broadcast_radius <= RADIUS_RST;
      st.max_hop_estimate <= HOP_RST;
      st.rebroadcast_slot_max <= SLOT_RST;
      st.mesh_retry_limit <= MESH_RETRY_RST;
      st.link_attempt_limit <= LINK_ATTEMPT_RST;
      st.rb_state <= RB_IDLE;
      st.lfsr <= LFSR_SEED;
      st.eff_radius <= RADIUS_MAX;
      st.relay_allow <= 1'b1; // a router after reset may relay
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign wb_dat_o = st.wb_dat;
  assign wb_ack_o = st.wb_ack;
  assign end_device_o = st.end_device;
  assign relay_allow_o = st.relay_allow;
  assign eff_radius_o = st.eff_radius;
  assign max_hop_estimate_o = st.max_hop_estimate;
  assign rebroadcast_go_o = st.rb_go;
  assign net_ack_req_o = st.net_ack_req;
  assign net_attempt_max_o = st.net_attempt_max;
  assign mac_ack_req_o = st.mac_ack_req;
  assign mac_attempt_max_o = st.mac_attempt_max;
  assign irq_o = st.irq;

endmodule // mldc_top
